// ---- verilog/tssf_regs.svh ----
// Register indices, field positions, reset values and counts
`ifndef TSSF_REGS_SVH
`define TSSF_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TSSF_IDX_FLAGS    8'h0C
`define TSSF_IDX_ENABLES  8'h8C
`define TSSF_IDX_OSCCTL   8'h8F
`define TSSF_IDX_TUNE     8'h90

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSSF_OSCFAIL_BIT  2
`define TSSF_FREQ_LSB     4
`define TSSF_FREQ_MSB     6
`define TSSF_STARTUP_BIT  3
`define TSSF_HFSTAB_BIT   2
`define TSSF_LFSTAB_BIT   1
`define TSSF_CLKSEL_BIT   0
`define TSSF_TUNE_MSB     4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TSSF_FLAGS_RESET  8'h00
`define TSSF_EN_RESET     8'h00
`define TSSF_FREQ_RESET   3'h6
`define TSSF_TUNE_RESET   5'h00
`define TSSF_OST_COUNT    11'h400
`define TSSF_SAMPLE_BIT   5
`define TSSF_BOOT_CYCLES  2'h3
`define TSSF_RESP_OKAY    2'h0
`define TSSF_RESP_SLVERR  2'h2

`endif

// ---- verilog/tssf_pkg.sv ----
// Types shared by the start-up and fail-safe clock block
package tssf_pkg;

  // ----------------------------------------------------------------
  // Oscillator configuration modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL, OSC_CRYSTAL, OSC_HIGH_SPEED_CRYSTAL,
    OSC_EXTERNAL_CLOCK, OSC_RES_CAP_CLKOUT, OSC_RES_CAP_IO,
    OSC_INTERNAL_CLKOUT, OSC_INTERNAL_IO
  } tssf_osc_mode_t;

  // Internal frequency select codes, in field order
  typedef enum logic [2:0] {
    FREQ_31K, FREQ_125K, FREQ_250K, FREQ_500K,
    FREQ_1M, FREQ_2M, FREQ_4M, FREQ_8M
  } tssf_freq_t;

  // ----------------------------------------------------------------
  // Pins and configuration levels from outside the clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic           extClk;
    logic           intClk;
    logic           lfClk;
    logic           sleepReq;
    logic           powerupTimerDone;
    logic           hfStable;
    logic           lfStable;
    logic           switchoverEnable;
    logic           failsafeEnable;
    logic           powerupTimerEnable;
    tssf_osc_mode_t oscMode;
  } tssf_pins_t;

  // ----------------------------------------------------------------
  // AXI4-Lite channels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } tssf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tssf_axi_rsp_t;

endpackage : tssf_pkg

// ---- verilog/tssf_clock_monitor.sv ----
// Two-speed start-up and fail-safe clock monitor with its registers
//
// Function
// - Status bit is 1 on the configured source, external or internal, 0 on internal.
// - Crystal modes count 1024 external cycles before calling it stable; the code counts only in two-speed start-up.
// - Two-speed only with switchover or monitor enabled, select bit clear, crystal mode.
// - Two-speed entered after power-on, power-up timer and every wake.
// - Non-crystal external modes skip two-speed start-up entirely.
// - Run internal; expiry, internal fall, set status, hold low, switch.
// - Sleep aborts any start-up count and leaves status bit clear.
// - Monitor works only when enabled, for every external clock option.
// - On failure set flag, request interrupt if enabled, go internal.
// - Failure clears status and watchdog; select and stable bits kept.
// - Sample clock is the low-frequency oscillator divided by 64.
// - Latch: clear at sample rise, set at clock fall, still clear fails.
// - Fail-safe internal frequency follows the writable select field.
// - Fail-safe ends on reset, on sleep, or on select bit change.
// - Fail flag cannot be cleared while fail-safe remains.
// - Monitor starts after power-up timer in clock/RC modes, after the 1024 count and switch in crystal.
// - Enabling the monitor also enables two-speed start-up.
// - Two read-only bits report high and low internal oscillator stable.
// - Select bit 1 picks internal, 0 the configured mode; resets to 0.
// - Status resets 0 with two-speed crystal or monitor enabled, else 1.
// - Any reset loads the frequency select field with 110.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`include "tssf_regs.svh"

module tssf_clock_monitor
  import tssf_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Register bus
  input  wire tssf_axi_req_t axiReq,
  output tssf_axi_rsp_t      axiRsp,
  // Oscillator pins and configuration levels
  input  wire tssf_pins_t    pinsIn,
  // Clock switch controls
  output logic               clkSelExt,
  output logic               clkHoldLow,
  output tssf_freq_t         intFreqSel,
  output logic [4:0]         oscillator_tuning,
  // System side effects
  output logic               watchdogClear,
  output logic               oscFailIrq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic isCrystal(input tssf_osc_mode_t m);
    isCrystal = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_CRYSTAL) ||
                (m == OSC_HIGH_SPEED_CRYSTAL);
  endfunction : isCrystal

  function automatic logic isExternal(input tssf_osc_mode_t m);
    isExternal = (m != OSC_INTERNAL_CLKOUT) && (m != OSC_INTERNAL_IO);
  endfunction : isExternal

  function automatic logic [7:0] regIndex(input logic [31:0] a);
    regIndex = a[9:2];
  endfunction : regIndex

  function automatic logic isMapped(input logic [31:0] a);
    logic [7:0] i;
    i = a[9:2];
    isMapped = (a[31:10] == 22'h000000) && (a[1:0] == 2'h0) &&
               ((i == `TSSF_IDX_FLAGS) || (i == `TSSF_IDX_ENABLES) ||
                (i == `TSSF_IDX_OSCCTL) || (i == `TSSF_IDX_TUNE));
  endfunction : isMapped

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  tssf_pins_t syncA_q;
  tssf_pins_t syncB_q;
  tssf_pins_t prevB_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      prevB_q <= '0;
    end else begin
      syncA_q <= pinsIn;
      syncB_q <= syncA_q;
      prevB_q <= syncB_q;
    end
  end

  wire extRise = syncB_q.extClk & ~prevB_q.extClk;
  wire extFall = ~syncB_q.extClk & prevB_q.extClk;
  wire intFall = ~syncB_q.intClk & prevB_q.intClk;
  wire lfRise  = syncB_q.lfClk & ~prevB_q.lfClk;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire crystalCfg  = isCrystal(syncB_q.oscMode);
  wire externalCfg = isExternal(syncB_q.oscMode);
  wire twoSpeedCfg = (syncB_q.switchoverEnable |
                      syncB_q.failsafeEnable) & crystalCfg;
  wire ostsInit    = ~(twoSpeedCfg | syncB_q.failsafeEnable);

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BOOT, ST_POWERUP, ST_TWO_SPEED, ST_WAIT_INT_FALL,
    ST_HOLD_LOW, ST_CONFIGURED, ST_FAILSAFE, ST_SLEEP
  } tssf_state_t;

  tssf_state_t state_q;
  tssf_state_t state_d;
  logic [1:0]  bootCnt_q;
  logic [10:0] ostCnt_q;
  logic [5:0]  lfDiv_q;
  logic        sampleClk_q;
  logic        monLatch_q;
  logic        startup_timeout_status_q;
  logic        startup_timeout_status_d;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  enables_q;
  logic [2:0]  freq_q;
  logic        clkSel_q;
  logic [4:0]  tune_q;
  logic        awHave_q;
  logic        wHave_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire awTake  = axiReq.awvalid & axiRsp.awready;
  wire wTake   = axiReq.wvalid & axiRsp.wready;
  wire arTake  = axiReq.arvalid & axiRsp.arready;
  wire doWrite = awHave_q & wHave_q & ~axiRsp.bvalid;
  wire wrOk    = doWrite & isMapped(awAddr_q) & wStrb_q[0];
  wire [7:0] wrIdx = regIndex(awAddr_q);
  wire [7:0] wrByte = wData_q[7:0];
  wire wrFlags = wrOk & (wrIdx == `TSSF_IDX_FLAGS);
  wire wrEn    = wrOk & (wrIdx == `TSSF_IDX_ENABLES);
  wire wrOsc   = wrOk & (wrIdx == `TSSF_IDX_OSCCTL);
  wire wrTune  = wrOk & (wrIdx == `TSSF_IDX_TUNE);
  wire clkSelChange = wrOsc &
                      (wrByte[`TSSF_CLKSEL_BIT] != clkSel_q);
  wire clkSel_d = wrOsc ? wrByte[`TSSF_CLKSEL_BIT] : clkSel_q;

  wire [7:0] oscCtlRead = {1'b0, freq_q, startup_timeout_status_q,
                           syncB_q.hfStable, syncB_q.lfStable,
                           clkSel_q};
  wire [7:0] rdIdx = regIndex(axiReq.araddr);
  wire       rdOk  = isMapped(axiReq.araddr);
  wire [7:0] rdByte =
    !rdOk                       ? 8'h00 :
    (rdIdx == `TSSF_IDX_FLAGS)   ? flags_q :
    (rdIdx == `TSSF_IDX_ENABLES) ? enables_q :
    (rdIdx == `TSSF_IDX_OSCCTL)  ? oscCtlRead :
                                   {3'h0, tune_q};

  // ----------------------------------------------------------------
  // Fail-safe monitor
  // ----------------------------------------------------------------
  wire sampleNow  = lfDiv_q[`TSSF_SAMPLE_BIT];
  wire sampleRise = sampleNow & ~sampleClk_q;
  wire sampleFall = ~sampleNow & sampleClk_q;
  wire monitorOn  = syncB_q.failsafeEnable & externalCfg &
                    (state_q == ST_CONFIGURED) & ~clkSel_q;
  wire failDetect = monitorOn & sampleFall & ~monLatch_q;
  wire monLatch_d = extFall    ? 1'b1 :
                    sampleRise ? 1'b0 : monLatch_q;

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  wire startTwoSpeed = twoSpeedCfg & ~clkSel_q;
  wire ostDone = (ostCnt_q == `TSSF_OST_COUNT);
  wire failEnter = (state_q == ST_CONFIGURED) & (state_d == ST_FAILSAFE);

  always_comb begin
    state_d = state_q;
    startup_timeout_status_d  = startup_timeout_status_q;
    if (state_q != ST_BOOT && syncB_q.sleepReq) begin
      state_d = ST_SLEEP;
      startup_timeout_status_d  = 1'b0;
    end else begin
      unique case (state_q)
        ST_BOOT: begin
          if (bootCnt_q == `TSSF_BOOT_CYCLES) begin
            state_d = ST_POWERUP;
            startup_timeout_status_d  = ostsInit;
          end
        end
        ST_POWERUP, ST_SLEEP: begin
          if (state_q == ST_SLEEP || !syncB_q.powerupTimerEnable ||
              syncB_q.powerupTimerDone) begin
            if (startTwoSpeed) begin
              state_d = ST_TWO_SPEED;
              startup_timeout_status_d  = 1'b0;
            end else begin
              state_d = ST_CONFIGURED;
              startup_timeout_status_d  = 1'b1;
            end
          end
        end
        ST_TWO_SPEED: begin
          if (ostDone) begin
            state_d = ST_WAIT_INT_FALL;
          end
        end
        ST_WAIT_INT_FALL: begin
          if (intFall) begin
            state_d = ST_HOLD_LOW;
            startup_timeout_status_d  = 1'b1;
          end
        end
        ST_HOLD_LOW: begin
          if (extFall) begin
            state_d = ST_CONFIGURED;
          end
        end
        ST_CONFIGURED: begin
          if (failDetect) begin
            state_d = ST_FAILSAFE;
            startup_timeout_status_d  = 1'b0;
          end
        end
        ST_FAILSAFE: begin
          if (clkSelChange) begin
            state_d = ST_CONFIGURED;
            startup_timeout_status_d  = 1'b1;
          end
        end
      endcase
    end
  end

  // Fail flag: hardware set and the active fail-safe both beat a clear
  always_comb begin
    flags_d = wrFlags ? wrByte : flags_q;
    if (failEnter || state_q == ST_FAILSAFE) begin
      flags_d[`TSSF_OSCFAIL_BIT] = 1'b1;
    end
  end

  wire [7:0] enables_d = wrEn ? wrByte : enables_q;
  wire selExt_d = (state_d == ST_CONFIGURED) & ~clkSel_d &
                  externalCfg;

  // ----------------------------------------------------------------
  // Sequencer and monitor flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_BOOT;
      bootCnt_q   <= 2'h0;
      startup_timeout_status_q      <= 1'b0;
      ostCnt_q    <= 11'h000;
      lfDiv_q     <= 6'h00;
      sampleClk_q <= 1'b0;
      monLatch_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      startup_timeout_status_q      <= startup_timeout_status_d;
      sampleClk_q <= sampleNow;
      monLatch_q  <= monLatch_d;
      if (state_q == ST_BOOT) begin
        bootCnt_q <= bootCnt_q + 2'h1;
      end
      if (state_d != ST_TWO_SPEED) begin
        ostCnt_q <= 11'h000;
      end else if (extRise && !ostDone) begin
        ostCnt_q <= ostCnt_q + 11'h001;
      end
      if (lfRise) begin
        lfDiv_q <= lfDiv_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and clock controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q       <= `TSSF_FLAGS_RESET;
      enables_q     <= `TSSF_EN_RESET;
      freq_q        <= `TSSF_FREQ_RESET;
      clkSel_q      <= 1'b0;
      tune_q        <= `TSSF_TUNE_RESET;
      clkSelExt     <= 1'b0;
      clkHoldLow    <= 1'b0;
      intFreqSel    <= FREQ_4M;
      oscillator_tuning       <= `TSSF_TUNE_RESET;
      watchdogClear <= 1'b0;
      oscFailIrq    <= 1'b0;
    end else begin
      flags_q    <= flags_d;
      enables_q  <= enables_d;
      clkSel_q   <= clkSel_d;
      if (wrOsc) begin
        freq_q <= wrByte[`TSSF_FREQ_MSB:`TSSF_FREQ_LSB];
      end
      if (wrTune) begin
        tune_q <= wrByte[`TSSF_TUNE_MSB:0];
      end
      clkSelExt  <= selExt_d;
      clkHoldLow <= (state_d == ST_HOLD_LOW);
      intFreqSel <= tssf_freq_t'(wrOsc ?
                    wrByte[`TSSF_FREQ_MSB:`TSSF_FREQ_LSB] :
                    freq_q);
      oscillator_tuning    <= wrTune ? wrByte[`TSSF_TUNE_MSB:0] : tune_q;
      watchdogClear <= failEnter;
      oscFailIrq <= flags_d[`TSSF_OSCFAIL_BIT] &
                    enables_d[`TSSF_OSCFAIL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire awHave_d = (awHave_q | awTake) & ~doWrite;
  wire wHave_d  = (wHave_q | wTake) & ~doWrite;
  wire bvalid_d = doWrite | (axiRsp.bvalid & ~axiReq.bready);
  wire rvalid_d = arTake | (axiRsp.rvalid & ~axiReq.rready);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 32'h00000000;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      axiRsp   <= '0;
    end else begin
      awHave_q <= awHave_d;
      wHave_q  <= wHave_d;
      if (awTake) begin
        awAddr_q <= axiReq.awaddr;
      end
      if (wTake) begin
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
      axiRsp.awready <= ~awHave_d & ~bvalid_d;
      axiRsp.wready  <= ~wHave_d & ~bvalid_d;
      axiRsp.bvalid  <= bvalid_d;
      if (doWrite) begin
        axiRsp.bresp <= isMapped(awAddr_q) ? `TSSF_RESP_OKAY :
                                             `TSSF_RESP_SLVERR;
      end
      axiRsp.arready <= ~rvalid_d;
      axiRsp.rvalid  <= rvalid_d;
      if (arTake) begin
        axiRsp.rdata <= {24'h000000, rdByte};
        axiRsp.rresp <= rdOk ? `TSSF_RESP_OKAY : `TSSF_RESP_SLVERR;
      end
    end
  end

endmodule : tssf_clock_monitor

// ---- testbench/tssf_clock_monitor_chk.sv ----
// Port assertions for the start-up and fail-safe clock block
`timescale 1ns/1ns
module tssf_clock_monitor_chk
  import tssf_pkg::*;
(
  // Clock and reset
  input wire logic          ref_clk,
  input wire logic          rst_n,
  // Register bus
  input wire tssf_axi_req_t axiReq,
  input wire tssf_axi_rsp_t axiRsp,
  // Pins and clock switch
  input wire tssf_pins_t    pinsIn,
  input wire logic          clkSelExt,
  input wire logic          clkHoldLow,
  input wire tssf_freq_t    intFreqSel,
  input wire logic [4:0]    oscillator_tuning,
  input wire logic          watchdogClear,
  input wire logic          oscFailIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Clock switch
  // ----------------------------------------------------------------
  sequence switchDone;
    !clkHoldLow && clkSelExt;
  endsequence

  hold_bound_a: assert property ($rose(clkHoldLow) |-> ##[1:20] switchDone)
    else $error("hold low phase did not end in a switch");
  hold_end_a: assert property ($fell(clkHoldLow) |-> switchDone)
    else $error("hold low ended without external select");
  ext_nohold_a: assert property ((pinsIn.oscMode == OSC_EXTERNAL_CLOCK) [*4]
    |-> !clkHoldLow)
    else $error("hold low in external clock mode");
  sleep_int_a: assert property (pinsIn.sleepReq [*8] |-> !clkSelExt)
    else $error("external select kept during sleep");
  fail_int_a: assert property (watchdogClear |=> !clkSelExt)
    else $error("fail-safe entry kept external select");
  wdog_pulse_a: assert property (watchdogClear |=> !watchdogClear)
    else $error("watchdog clear longer than one cycle");
  freq_reset_a: assert property ($rose(rst_n) |-> intFreqSel == FREQ_4M)
    else $error("frequency select not 110 after reset");

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  rd_lat_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  ar_block_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read address taken while answer pending");
  bad_read_a: assert property (axiRsp.rvalid && axiRsp.rresp == 2'h2
    |-> axiRsp.rdata == 32'h0)
    else $error("error read returned data");
  b_refuse_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
endmodule : tssf_clock_monitor_chk

bind tssf_clock_monitor tssf_clock_monitor_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
  .pinsIn(pinsIn), .clkSelExt(clkSelExt), .clkHoldLow(clkHoldLow),
  .intFreqSel(intFreqSel), .oscillator_tuning(oscillator_tuning),
  .watchdogClear(watchdogClear), .oscFailIrq(oscFailIrq)
);

// ---- testbench/tssf_ext_osc.sv ----
// Behavioural external oscillator for the clock pin
`timescale 1ns/1ns
module tssf_ext_osc (
  // Controls
  input wire logic run,
  input wire logic slow,
  // Oscillator pin
  output logic     extClk
);
  // A stopped oscillator holds its last level, as a dead crystal does
  initial extClk = 1'b0;
  always begin
    #(slow ? 60 : 40);
    if (run) extClk = ~extClk;
  end
endmodule : tssf_ext_osc

// ---- testbench/testbench.sv ----
// Self-checking bench for the start-up and fail-safe clock block
`timescale 1ns/1ns
`include "tssf_regs.svh"
module testbench;
  import tssf_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] flgA = {22'h0, `TSSF_IDX_FLAGS, 2'h0};
  localparam logic [31:0] enaA = {22'h0, `TSSF_IDX_ENABLES, 2'h0};
  localparam logic [31:0] ctlA = {22'h0, `TSSF_IDX_OSCCTL, 2'h0};
  localparam logic [31:0] tunA = {22'h0, `TSSF_IDX_TUNE, 2'h0};
  logic           ref_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           intClk = 1'b0;
  logic           lfClk = 1'b0;
  logic           sleepReq = 1'b0;
  logic           ptDone = 1'b0;
  logic           fsEn = 1'b1;
  logic           run = 1'b1;
  logic           slow = 1'b0;
  logic           extClk;
  tssf_osc_mode_t oscMode = OSC_CRYSTAL;
  tssf_axi_req_t  axiReq = '0;
  tssf_axi_rsp_t  axiRsp;
  tssf_pins_t     pinsIn;
  logic           clkSelExt, clkHoldLow, watchdogClear, oscFailIrq;
  tssf_freq_t     intFreqSel;
  logic [4:0]     oscillator_tuning;
  logic [31:0]    rd;
  logic [1:0]     rsp;
  int             failures = 0;
  int             numChecks = 0;
  int             extRises = 0;

  assign pinsIn = {extClk, intClk, lfClk, sleepReq, ptDone, 1'b1, 1'b0,
                   1'b0, fsEn, 1'b1, oscMode};
  always #4 ref_clk = ~ref_clk;
  always #20 intClk = ~intClk;
  always #24 lfClk = ~lfClk;
  always @(posedge extClk) extRises++;

  tssf_ext_osc u_tssf_ext_osc (.run(run), .slow(slow), .extClk(extClk));
  tssf_clock_monitor u_tssf_clock_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .pinsIn(pinsIn), .clkSelExt(clkSelExt), .clkHoldLow(clkHoldLow),
    .intFreqSel(intFreqSel), .oscillator_tuning(oscillator_tuning),
    .watchdogClear(watchdogClear), .oscFailIrq(oscFailIrq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk_val(input string n, input logic [31:0] e, g);
    numChecks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string n, input logic e, g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  task automatic timeout(input string n);
    failures++;
    $display("FAIL %s expected done seen timeout", n);
    print_verdict();
  endtask : timeout

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  // Waits for clkSelExt (sel 0) or watchdogClear (sel 1) to reach lvl
  task automatic wait_for(input string n, input logic sel, lvl, input int b);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while ((sel ? watchdogClear : clkSelExt) !== lvl && k < b);
    if ((sel ? watchdogClear : clkSelExt) !== lvl) timeout(n);
    @(posedge ref_clk);
  endtask : wait_for

  task automatic axi_write(input logic [31:0] a, input logic [7:0] d,
                           input logic [3:0] s = 4'hF);
    int k;
    logic awr, wr, bv;
    k = 0;
    @(posedge ref_clk);
    axiReq <= {1'b1, a, 1'b1, {24'h0, d}, s, 1'b1, 1'b0, 32'h0, 1'b0};
    do begin
      @(negedge ref_clk);
      awr = axiRsp.awready;
      wr = axiRsp.wready;
      bv = axiRsp.bvalid;
      rsp = axiRsp.bresp;
      @(posedge ref_clk);
      k++;
      if (awr) axiReq.awvalid <= 1'b0;
      if (wr) axiReq.wvalid <= 1'b0;
    end while (bv !== 1'b1 && k < 50);
    if (bv !== 1'b1) timeout("write");
    axiReq.bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a);
    int k;
    logic arr, rv;
    k = 0;
    @(posedge ref_clk);
    axiReq <= {1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    do begin
      @(negedge ref_clk);
      arr = axiRsp.arready;
      rv = axiRsp.rvalid;
      rd = axiRsp.rdata;
      rsp = axiRsp.rresp;
      @(posedge ref_clk);
      k++;
      if (arr) axiReq.arvalid <= 1'b0;
    end while (rv !== 1'b1 && k < 50);
    if (rv !== 1'b1) timeout("read");
    axiReq.rready <= 1'b0;
  endtask : axi_read

  task automatic rd_chk(input string n, input logic [31:0] a,
                        input logic [7:0] e);
    axi_read(a);
    chk_val(n, {24'h0, e}, rd);
    chk_val("read resp", 32'h0, {30'h0, rsp});
  endtask : rd_chk

  task automatic sc_switch(input string n, input int b);
    wait_for(n, 1'b0, 1'b1, b);
    chk_bit("count window", 1'b1, extRises >= 1024 && extRises <= 1030);
    rd_chk("ctl external", ctlA, 8'h6C);
  endtask : sc_switch

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_regs;
    cycles(10);
    rd_chk("ctl reset", ctlA, 8'h64);
    rd_chk("flags reset", flgA, 8'h00);
    rd_chk("enables reset", enaA, 8'h00);
    rd_chk("tune reset", tunA, 8'h00);
    axi_read(32'h4);
    chk_val("bad read", 32'h2, {30'h0, rsp});
    cycles(2000);
    chk_bit("powerup wait", 1'b0, clkSelExt);
  endtask : sc_reset_regs

  task automatic sc_regs;
    for (int c = 0; c < 8; c++) begin
      axi_write(ctlA, {1'b0, c[2:0], 4'h0});
      cycles(2);
      chk_val("freq out", c, {29'h0, intFreqSel});
      rd_chk("ctl freq", ctlA, {1'b0, c[2:0], 4'hC});
    end
    axi_write(tunA, 8'hFF);
    rd_chk("tune", tunA, 8'h1F);
    chk_val("tune out", 32'h1F, {27'h0, oscillator_tuning});
    axi_write(tunA, 8'h00, 4'h0);
    rd_chk("tune kept", tunA, 8'h1F);
    axi_write(32'h244, 8'h55);
    chk_val("bad write", 32'h2, {30'h0, rsp});
    axi_write(ctlA, 8'h60);
  endtask : sc_regs

  task automatic sc_sleep;
    sleepReq <= 1'b1;
    wait_for("sleep drop", 1'b0, 1'b0, 20);
    rd_chk("ctl asleep", ctlA, 8'h64);
    sleepReq <= 1'b0;
    slow <= 1'b1;
    cycles(400);
    sleepReq <= 1'b1;
    cycles(20);
    rd_chk("ctl abort", ctlA, 8'h64);
    sleepReq <= 1'b0;
    extRises = 0;
    sc_switch("wake switch", 20000);
  endtask : sc_sleep

  task automatic sc_fail;
    slow <= 1'b0;
    axi_write(enaA, 8'h04);
    run <= 1'b0;
    wait_for("fail detect", 1'b1, 1'b1, 2000);
    cycles(3);
    chk_bit("fail internal", 1'b0, clkSelExt);
    chk_bit("fail irq", 1'b1, oscFailIrq);
    rd_chk("fail flag", flgA, 8'h04);
    rd_chk("ctl failsafe", ctlA, 8'h64);
    axi_write(flgA, 8'h00);
    rd_chk("flag sticky", flgA, 8'h04);
    axi_write(ctlA, 8'h40);
    chk_val("failsafe freq", 32'h4, {29'h0, intFreqSel});
    chk_bit("still internal", 1'b0, clkSelExt);
    axi_write(enaA, 8'h00);
    cycles(2);
    chk_bit("irq masked", 1'b0, oscFailIrq);
    run <= 1'b1;
    axi_write(ctlA, 8'h41);
    axi_write(ctlA, 8'h60);
    wait_for("failsafe exit", 1'b0, 1'b1, 400);
    axi_write(flgA, 8'h00);
    rd_chk("flag cleared", flgA, 8'h00);
  endtask : sc_fail

  task automatic sc_ext_mode;
    axi_write(ctlA, 8'h20);
    rst_n <= 1'b0;
    oscMode <= OSC_EXTERNAL_CLOCK;
    cycles(4);
    rst_n <= 1'b1;
    cycles(1);
    chk_val("freq after reset", 32'h6, {29'h0, intFreqSel});
    wait_for("direct switch", 1'b0, 1'b1, 30);
    rd_chk("ctl direct", ctlA, 8'h6C);
    run <= 1'b0;
    wait_for("direct fail", 1'b1, 1'b1, 2000);
  endtask : sc_ext_mode

  initial begin
    cycles(4);
    rst_n <= 1'b1;
    sc_reset_regs();
    ptDone <= 1'b1;
    extRises = 0;
    sc_switch("first switch", 12000);
    sc_regs();
    sc_sleep();
    sc_fail();
    sc_ext_mode();
    print_verdict();
  end
endmodule : testbench
